// ===== src/ubt_top.v
`include "ubt_regs.vh"
`default_nettype none

module ubt_top #(
  parameter AW = 4,
  parameter DW = 8
) (
  // clock and reset
  input  wire          CLK,
  input  wire          SYS_RST,
  // register port
  input  wire [AW-1:0] ADDR,
  input  wire [DW-1:0] WDATA,
  input  wire          WR,
  input  wire          RD,
  output wire [DW-1:0] RDATA,
  // bit rate sources
  input  wire          EXT_SERIAL_CLK_IN,
  input  wire          AUX_CLK,
  input  wire          SUBMAIN_CLK,
  // interrupt system
  input  wire          GLOBAL_IRQ_ENABLE,
  input  wire          TX_IRQ_ACK,
  input  wire          RX_IRQ_ACK,
  output wire          TX_IRQ,
  output wire          RX_IRQ,
  // serial line
  input  wire          SERIAL_RECEIVE_PIN,
  output wire          SERIAL_TRANSMIT_PIN
);

  localparam CW = 17;
  localparam TX_IDLE = 1'b0;
  localparam TX_RUN  = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_RUN  = 1'b1;

  // software registers
  reg [7:0]  ctrl_reg;
  reg [7:0]  mod_reg;
  reg [7:0]  div_lo_reg;
  reg [7:0]  div_hi_reg;
  reg [7:0]  tx_hold_reg;
  reg        tx_hold_full_reg;
  reg [7:0]  rx_buf_reg;
  reg [1:0]  irq_en_reg;
  reg [1:0]  irq_flag_reg;
  reg        frame_err_reg;
  reg        par_err_reg;
  reg [DW-1:0] rdata_reg;
  reg        tx_irq_reg;
  reg        rx_irq_reg;

  // transmitter state
  reg        tx_state_reg;
  reg [11:0] tx_frame_reg;
  reg [3:0]  tx_idx_reg;
  reg [3:0]  tx_last_reg;
  reg        txd_reg;

  // receiver state
  reg        rx_state_reg;
  reg [11:0] rx_bits_reg;
  reg [3:0]  rx_idx_reg;
  reg [3:0]  rx_last_reg;
  reg        rxd_prev_reg;

  // source clock edge detect
  reg        src_prev_reg;

  wire        hold     = ctrl_reg[`UBT_CTRL_HOLD];
  wire [1:0]  src_sel  = ctrl_reg[`UBT_CTRL_SEL_HI:`UBT_CTRL_SEL_LO];
  wire        char8    = ctrl_reg[`UBT_CTRL_CHAR8];
  wire        pen      = ctrl_reg[`UBT_CTRL_PEN];
  wire        peven    = ctrl_reg[`UBT_CTRL_PEVEN];
  wire        stop2    = ctrl_reg[`UBT_CTRL_STOP2];
  wire [15:0] divisor  = {div_hi_reg, div_lo_reg};

  wire wr_ctrl  = WR && (ADDR == `UBT_OFS_CTRL);
  wire wr_txbuf = WR && (ADDR == `UBT_OFS_TX_BUF);
  wire wr_flag  = WR && (ADDR == `UBT_OFS_IRQ_FLAG);
  wire rd_rxbuf = RD && (ADDR == `UBT_OFS_RX_BUF);

  // source select; sources are sampled levels, so one tick per rising edge
  reg src_level;
  always @*
  begin
    case (src_sel)
      `UBT_SEL_EXT: src_level = EXT_SERIAL_CLK_IN;
      `UBT_SEL_AUX: src_level = AUX_CLK;
      default:      src_level = SUBMAIN_CLK;
    endcase
  end

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      src_prev_reg <= 1'b0;
    else
      src_prev_reg <= src_level;
  end

  wire src_tick = src_level && !src_prev_reg;

  // per-bit length: base divisor plus the wrapped modulation bit
  wire [CW-1:0] tx_len_cur = {1'b0, divisor} + {{(CW-1){1'b0}}, mod_reg[tx_idx_reg[2:0]]};
  wire [3:0]    tx_idx_inc = tx_idx_reg + 4'h1;
  wire [CW-1:0] tx_len_nxt = {1'b0, divisor} + {{(CW-1){1'b0}}, mod_reg[tx_idx_inc[2:0]]};
  wire [3:0]    rx_idx_inc = rx_idx_reg + 4'h1;
  wire [CW-1:0] rx_len_half = {2'b00, divisor[15:1]} + {{(CW-1){1'b0}}, mod_reg[0]};
  wire [CW-1:0] rx_len_nxt = {1'b0, divisor} + {{(CW-1){1'b0}}, mod_reg[rx_idx_inc[2:0]]};

  // frame assembly, start bit first, stops stay one
  wire [3:0] dlen    = char8 ? 4'h8 : 4'h7;
  wire [7:0] tx_data = char8 ? tx_hold_reg : {1'b0, tx_hold_reg[6:0]};
  wire       tx_par  = peven ? (^tx_data) : ~(^tx_data);
  reg [11:0] tx_frame_new;
  integer i;
  always @*
  begin
    tx_frame_new = 12'hfff;
    tx_frame_new[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      if (i < dlen)
        tx_frame_new[1+i] = tx_data[i];
    if (pen)
      tx_frame_new[dlen+4'h1] = tx_par;
  end
  wire [3:0] tx_last_new = dlen + {3'b000, pen} + {3'b000, stop2} + 4'h1;

  // transmitter: loads the holding buffer on a source tick once idle
  wire tx_start = (tx_state_reg == TX_IDLE) && tx_hold_full_reg && !hold && src_tick;
  wire tx_tick;
  wire tx_done  = tx_tick && (tx_idx_reg == tx_last_reg);

  ubt_baud_gen #(
    .CW (CW)
  ) u_tx_baud (
    .clk        (CLK),
    .rst        (SYS_RST),
    .src_tick   (src_tick),
    .run        (((tx_state_reg == TX_RUN) || tx_start) && !hold),
    .load       (tx_start),
    .load_len   (tx_len_cur),
    .reload_len (tx_len_nxt),
    .bit_tick   (tx_tick)
  );

  // bit j ends after the sum of lengths 0..j since each period starts as the last ends
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_state_reg <= TX_IDLE;
      tx_frame_reg <= 12'hfff;
      tx_idx_reg   <= 4'h0;
      tx_last_reg  <= 4'h0;
      txd_reg      <= 1'b1;
    end
    else if (hold)
    begin
      tx_state_reg <= TX_IDLE;
      tx_idx_reg   <= 4'h0;
      txd_reg      <= 1'b1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          txd_reg <= 1'b1;
          if (tx_start)
          begin
            tx_state_reg <= TX_RUN;
            tx_frame_reg <= tx_frame_new;
            tx_last_reg  <= tx_last_new;
            tx_idx_reg   <= 4'h0;
            txd_reg      <= 1'b0;
          end
        end
        TX_RUN:
        begin
          if (tx_done)
          begin
            tx_state_reg <= TX_IDLE;
            tx_idx_reg   <= 4'h0;
            txd_reg      <= 1'b1;
          end
          else if (tx_tick)
          begin
            tx_idx_reg <= tx_idx_inc;
            txd_reg    <= tx_frame_reg[tx_idx_inc];
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // receiver: falling edge starts, half period to the start bit centre
  wire rxd      = SERIAL_RECEIVE_PIN;
  wire rx_start = (rx_state_reg == RX_IDLE) && !hold && rxd_prev_reg && !rxd;
  wire rx_tick;
  wire rx_false = rx_tick && (rx_idx_reg == 4'h0) && rxd;
  wire rx_done  = rx_tick && (rx_idx_reg == rx_last_reg) && !rx_false;
  wire [3:0] rx_last_new = dlen + {3'b000, pen} + 4'h1;

  ubt_baud_gen #(
    .CW (CW)
  ) u_rx_baud (
    .clk        (CLK),
    .rst        (SYS_RST),
    .src_tick   (src_tick),
    .run        (((rx_state_reg == RX_RUN) || rx_start) && !hold),
    .load       (rx_start),
    .load_len   (rx_len_half),
    .reload_len (rx_len_nxt),
    .bit_tick   (rx_tick)
  );

  // one sample per bit centre; the receiver checks only the first stop bit
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_state_reg <= RX_IDLE;
      rx_bits_reg  <= 12'h000;
      rx_idx_reg   <= 4'h0;
      rx_last_reg  <= 4'h0;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_prev_reg <= rxd;
      if (hold)
      begin
        rx_state_reg <= RX_IDLE;
        rx_idx_reg   <= 4'h0;
      end
      else
      begin
        case (rx_state_reg)
          RX_IDLE:
          begin
            if (rx_start)
            begin
              rx_state_reg <= RX_RUN;
              rx_idx_reg   <= 4'h0;
              rx_last_reg  <= rx_last_new;
            end
          end
          RX_RUN:
          begin
            if (rx_tick)
            begin
              rx_bits_reg[rx_idx_reg] <= rxd;
              rx_idx_reg <= rx_idx_inc;
              if (rx_false || rx_done)
                rx_state_reg <= RX_IDLE;
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // received character checks; the stop bit is the sample of this cycle
  wire [7:0] rx_data  = char8 ? rx_bits_reg[8:1] : {1'b0, rx_bits_reg[7:1]};
  wire       rx_parb  = char8 ? rx_bits_reg[9] : rx_bits_reg[8];
  wire       rx_perr  = pen && ((^{rx_data, rx_parb}) == peven);

  // tx free flag set event: holding buffer just moved into the shift register
  wire tx_free_set = tx_start;
  wire tx_free_clr = wr_txbuf || TX_IRQ_ACK || (wr_flag && WDATA[`UBT_IRQ_TX]);
  wire rx_flag_clr = rd_rxbuf || RX_IRQ_ACK || (wr_flag && WDATA[`UBT_IRQ_RX]);

  // software registers and sticky flags; a set in the clearing cycle wins unless the clear comes from hold
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl_reg         <= `UBT_RST_CTRL;
      mod_reg          <= `UBT_RST_MOD;
      div_lo_reg       <= `UBT_RST_DIV_LO;
      div_hi_reg       <= `UBT_RST_DIV_HI;
      tx_hold_reg      <= 8'h00;
      tx_hold_full_reg <= 1'b0;
      rx_buf_reg       <= 8'h00;
      irq_en_reg       <= `UBT_RST_IRQ_EN;
      irq_flag_reg     <= `UBT_RST_IRQ_FLAG;
      frame_err_reg    <= 1'b0;
      par_err_reg      <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= WDATA;
      if (WR && (ADDR == `UBT_OFS_MOD))
        mod_reg <= WDATA;
      if (WR && (ADDR == `UBT_OFS_DIV_LO))
        div_lo_reg <= WDATA;
      if (WR && (ADDR == `UBT_OFS_DIV_HI))
        div_hi_reg <= WDATA;
      if (WR && (ADDR == `UBT_OFS_IRQ_EN))
        irq_en_reg <= WDATA[1:0];

      // holding buffer; a write while full overwrites the waiting character
      if (wr_txbuf)
      begin
        tx_hold_reg      <= WDATA;
        tx_hold_full_reg <= 1'b1;
      end
      else if (tx_start)
        tx_hold_full_reg <= 1'b0;

      // free flag
      if (tx_free_set)
        irq_flag_reg[`UBT_IRQ_TX] <= 1'b1;
      else if (tx_free_clr)
        irq_flag_reg[`UBT_IRQ_TX] <= 1'b0;

      // receive flag and error bits
      if (rx_done)
      begin
        rx_buf_reg                <= rx_data;
        irq_flag_reg[`UBT_IRQ_RX] <= 1'b1;
        frame_err_reg             <= !rxd;
        par_err_reg               <= rx_perr;
      end
      else if (rx_flag_clr)
      begin
        irq_flag_reg[`UBT_IRQ_RX] <= 1'b0;
        if (rd_rxbuf)
        begin
          frame_err_reg <= 1'b0;
          par_err_reg   <= 1'b0;
        end
      end

      // hold forces the free flag, drops enables and empties the buffer
      if (hold || (wr_ctrl && WDATA[`UBT_CTRL_HOLD]))
      begin
        irq_flag_reg[`UBT_IRQ_TX] <= 1'b1;
        irq_en_reg[`UBT_IRQ_TX]   <= 1'b0;
        irq_flag_reg[`UBT_IRQ_RX] <= 1'b0;
        irq_en_reg[`UBT_IRQ_RX]   <= 1'b0;
        tx_hold_full_reg          <= 1'b0;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rdata_reg <= {DW{1'b0}};
    else if (RD)
    begin
      case (ADDR)
        `UBT_OFS_CTRL:     rdata_reg <= ctrl_reg;
        `UBT_OFS_MOD:      rdata_reg <= mod_reg;
        `UBT_OFS_DIV_LO:   rdata_reg <= div_lo_reg;
        `UBT_OFS_DIV_HI:   rdata_reg <= div_hi_reg;
        `UBT_OFS_TX_BUF:   rdata_reg <= tx_hold_reg;
        `UBT_OFS_RX_BUF:   rdata_reg <= rx_buf_reg;
        `UBT_OFS_IRQ_EN:   rdata_reg <= {6'h00, irq_en_reg};
        `UBT_OFS_IRQ_FLAG: rdata_reg <= {6'h00, irq_flag_reg};
        `UBT_OFS_STATUS:   rdata_reg <= {3'h0, par_err_reg, frame_err_reg,
                                         (tx_state_reg == TX_IDLE) && !tx_hold_full_reg,
                                         rx_state_reg, tx_state_reg};
        default:           rdata_reg <= {DW{1'b0}};
      endcase
    end
    else
      rdata_reg <= {DW{1'b0}};
  end

  // separate request lines per direction, registered so they never glitch
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
    end
    else
    begin
      tx_irq_reg <= irq_flag_reg[`UBT_IRQ_TX] && irq_en_reg[`UBT_IRQ_TX] && GLOBAL_IRQ_ENABLE;
      rx_irq_reg <= irq_flag_reg[`UBT_IRQ_RX] && irq_en_reg[`UBT_IRQ_RX] && GLOBAL_IRQ_ENABLE;
    end
  end

  assign RDATA               = rdata_reg;
  assign TX_IRQ              = tx_irq_reg;
  assign RX_IRQ              = rx_irq_reg;
  assign SERIAL_TRANSMIT_PIN = txd_reg;

endmodule // ubt_top

`default_nettype wire

// ===== src/ubt_regs.vh
`ifndef UBT_REGS_VH
`define UBT_REGS_VH

// register offsets, one byte each
`define UBT_OFS_CTRL      4'h0
`define UBT_OFS_MOD       4'h1
`define UBT_OFS_DIV_LO    4'h2
`define UBT_OFS_DIV_HI    4'h3
`define UBT_OFS_TX_BUF    4'h4
`define UBT_OFS_RX_BUF    4'h5
`define UBT_OFS_IRQ_EN    4'h6
`define UBT_OFS_IRQ_FLAG  4'h7
`define UBT_OFS_STATUS    4'h8

// control field positions
`define UBT_CTRL_HOLD     0
`define UBT_CTRL_SEL_LO   1
`define UBT_CTRL_SEL_HI   2
`define UBT_CTRL_CHAR8    3
`define UBT_CTRL_PEN      4
`define UBT_CTRL_PEVEN    5
`define UBT_CTRL_STOP2    6

// interrupt flag and enable field positions
`define UBT_IRQ_TX        0
`define UBT_IRQ_RX        1

// status field positions
`define UBT_ST_TX_BUSY    0
`define UBT_ST_RX_BUSY    1
`define UBT_ST_TX_EMPTY   2
`define UBT_ST_FRAME_ERR  3
`define UBT_ST_PAR_ERR    4

// source clock selections
`define UBT_SEL_EXT       2'h0
`define UBT_SEL_AUX       2'h1
`define UBT_SEL_SUB       2'h2

// reset values
`define UBT_RST_CTRL      8'h01
`define UBT_RST_MOD       8'h00
`define UBT_RST_DIV_LO    8'h03
`define UBT_RST_DIV_HI    8'h00
`define UBT_RST_IRQ_EN    2'h0
`define UBT_RST_IRQ_FLAG  2'h1

`endif

// ===== src/ubt_baud_gen.v
`default_nettype none

// bit period counter: counts source ticks, one pulse per finished period
module ubt_baud_gen #(
  parameter CW = 17
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // control
  input  wire          src_tick,
  input  wire          run,
  input  wire          load,
  input  wire [CW-1:0] load_len,
  input  wire [CW-1:0] reload_len,
  // result
  output wire          bit_tick
);

  reg [CW-1:0] cnt_reg;
  reg          tick_reg;

  // a length of zero still yields one source tick, never a stuck counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg  <= {CW{1'b0}};
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= 1'b0;
      if (!run)
        cnt_reg <= {CW{1'b0}};
      else if (load)
        cnt_reg <= load_len;
      else if (src_tick)
      begin
        if (cnt_reg <= {{(CW-1){1'b0}}, 1'b1})
        begin
          tick_reg <= 1'b1;
          cnt_reg  <= reload_len;
        end
        else
          cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign bit_tick = tick_reg;

endmodule // ubt_baud_gen

`default_nettype wire

// ===== sim/ubt_checker.sv
`default_nettype none
// watches the top ports for transmit interrupt gating and soft hold effects
module ubt_checker (
  // clock and reset
  input wire logic       CLK,
  input wire logic       SYS_RST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  // interrupts and line
  input wire logic       GLOBAL_IRQ_ENABLE,
  input wire logic       TX_IRQ_ACK,
  input wire logic       TX_IRQ,
  input wire logic       RX_IRQ,
  input wire logic       SERIAL_TRANSMIT_PIN,
  // bit rate sources, to know when a new character may start
  input wire logic       EXT_SERIAL_CLK_IN,
  input wire logic       AUX_CLK,
  input wire logic       SUBMAIN_CLK
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       hold_q;
  logic [1:0] sel_q;
  logic       src_q;
  // a start can only fall on a source tick, and a start sets the free flag again
  wire logic  src_lvl = (sel_q == 2'h0) ? EXT_SERIAL_CLK_IN : ((sel_q == 2'h1) ? AUX_CLK : SUBMAIN_CLK);
  wire logic  src_tk  = src_lvl && !src_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // hold and source select mirrored from control writes; hold is one out of reset
  always_ff @(posedge CLK or posedge SYS_RST)
    if (SYS_RST)
    begin
      hold_q <= 1'b1;
      sel_q  <= 2'h0;
      src_q  <= 1'b0;
    end
    else
    begin
      src_q <= src_lvl;
      if (WR && ADDR == 4'h0)
      begin
        hold_q <= WDATA[0];
        sel_q  <= WDATA[2:1];
      end
    end
  // the request is registered, so its cause is one cycle back
  AST_TX_GLOBAL: assert property (TX_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("tx irq without global enable");
  AST_EN_OFF: assert property (WR && ADDR == 4'h6 && !WDATA[0] |-> ##2 !TX_IRQ)
    else $error("tx irq after enable cleared");
  AST_BUF_CLR: assert property (WR && ADDR == 4'h4 && !hold_q && !src_tk ##1 !src_tk |=> !TX_IRQ)
    else $error("tx irq after buffer write");
  AST_ACK_CLR: assert property (TX_IRQ_ACK && TX_IRQ && !hold_q && !$past(WR) && !src_tk ##1 !src_tk |=> !TX_IRQ)
    else $error("tx irq after service");
  AST_HOLD_IRQ: assert property (hold_q && $past(hold_q) |-> !TX_IRQ)
    else $error("tx irq while held");
  AST_HOLD_LINE: assert property (hold_q && $past(hold_q) |-> SERIAL_TRANSMIT_PIN)
    else $error("line active while held");
  AST_RX_GLOBAL: assert property (RX_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("rx irq without global enable");
  AST_IRQ_KEEP: assert property (TX_IRQ && GLOBAL_IRQ_ENABLE && !$past(WR) && !$past(TX_IRQ_ACK) |=> TX_IRQ)
    else $error("tx irq dropped without cause");
  // main scenarios
  COV_TX_IRQ: cover property ($rose(TX_IRQ));
  COV_RX_IRQ: cover property ($rose(RX_IRQ));
  COV_FRAME: cover property ($fell(SERIAL_TRANSMIT_PIN));
endmodule // ubt_checker

bind ubt_top ubt_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .TX_IRQ_ACK(TX_IRQ_ACK), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ),
  .SERIAL_TRANSMIT_PIN(SERIAL_TRANSMIT_PIN), .EXT_SERIAL_CLK_IN(EXT_SERIAL_CLK_IN), .AUX_CLK(AUX_CLK),
  .SUBMAIN_CLK(SUBMAIN_CLK));
`default_nettype wire

// ===== sim/ubt_partner.sv
`default_nettype none
// far end of the line: times the device's bits and sends frames to it
module ubt_partner (
  // clock and source
  input wire logic        clk,
  input wire logic        src,
  // line and timing
  input wire logic        tx_line,
  input wire logic [15:0] div,
  input wire logic [7:0]  mod,
  output var logic        rx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic src_q = 1'b0;
  logic tx_q = 1'b1;
  int   ticks = 0;
  int   n_edges = 0;
  int   len [0:15];
  wire  tick = src & ~src_q;
  initial rx_line = 1'b1;
  // bit lengths in source ticks between line edges; lag is constant so it cancels
  always @(posedge clk)
  begin
    src_q <= src;
    tx_q <= tx_line;
    if (tx_line != tx_q)
    begin
      if (n_edges > 0 && n_edges < 17)
        len[n_edges-1] <= ticks;
      n_edges <= n_edges + 1;
      ticks <= int'(tick);
    end
    else
      ticks <= ticks + int'(tick);
  end
  // start, eight data lsb first, one stop; ten bits so the pattern wraps
  task automatic send(input logic [7:0] data);
    logic [9:0] fr;
    int         k;
    fr = {1'b1, data, 1'b0};
    for (k = 0; k < 10; k++)
    begin
      rx_line <= fr[k];
      repeat (div + mod[k % 8]) @(posedge clk iff tick);
    end
  endtask
endmodule // ubt_partner
`default_nettype wire

// ===== sim/ubt_top_tb.sv
`default_nettype none
module ubt_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] sel; logic [15:0] div; logic [7:0] mod; logic [7:0] rxd;} ubt_row_t;
  ubt_row_t rows [3] = '{{2'h1, 16'h0003, 8'h4a, 8'ha5}, {2'h0, 16'h000d, 8'h6b, 8'h3c},
                         {2'h2, 16'h0103, 8'h01, 8'hc3}};
  logic       CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       GLOBAL_IRQ_ENABLE = 1'b0;
  logic       TX_IRQ_ACK = 1'b0;
  logic       RX_IRQ_ACK = 1'b0;
  logic [1:0] sel = 2'h1;
  logic [1:0] sc = 2'h0;
  logic [2:0] ac = 3'h0;
  logic       src = 1'b0;
  logic       alt = 1'b0;
  logic [7:0] v;
  // the partner's frame timing follows the row under test
  logic [15:0] far_div = 16'h0003;
  logic [7:0]  far_mod = 8'h00;
  wire logic [7:0] RDATA;
  wire logic  TX_IRQ, RX_IRQ, SERIAL_TRANSMIT_PIN, SERIAL_RECEIVE_PIN;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         i, k;
  always #5 CLK = ~CLK;
  // selected source ticks every 4 cycles, the others every 6 so a wrong pick shows
  always @(posedge CLK)
  begin
    sc <= sc + 2'h1;
    src <= sc[1];
    ac <= (ac == 3'h5) ? 3'h0 : ac + 3'h1;
    alt <= (ac > 3'h2);
  end
  ubt_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EXT_SERIAL_CLK_IN(sel == 2'h0 ? src : alt), .AUX_CLK(sel == 2'h1 ? src : alt),
    .SUBMAIN_CLK(sel == 2'h2 ? src : alt), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .TX_IRQ_ACK(TX_IRQ_ACK),
    .RX_IRQ_ACK(RX_IRQ_ACK), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .SERIAL_RECEIVE_PIN(SERIAL_RECEIVE_PIN),
    .SERIAL_TRANSMIT_PIN(SERIAL_TRANSMIT_PIN));
  ubt_partner u_far (.clk(CLK), .src(src), .tx_line(SERIAL_TRANSMIT_PIN), .div(far_div),
    .mod(far_mod), .rx_line(SERIAL_RECEIVE_PIN));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes; a free cycle between accesses keeps each strobe single-driven
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: the slowest row needs two frames of about 10400 cycles each
  initial
  begin
    #400us;
    error_cnt++;
    results;
  end
  initial
  begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    GLOBAL_IRQ_ENABLE <= 1'b1;
    foreach (rows[r])
    begin
      sel <= rows[r].sel;
      far_div <= rows[r].div;
      far_mod <= rows[r].mod;
      wr(4'h1, rows[r].mod);
      wr(4'h2, rows[r].div[7:0]);
      wr(4'h3, rows[r].div[15:8]);
      wr(4'h0, {4'h0, 1'b1, rows[r].sel, 1'b0});
      wr(4'h6, 8'h02);
      u_far.n_edges = 0;
      wr(4'h4, 8'h55);
      for (i = 0; i < 20000 && u_far.n_edges < 10; i++) @(posedge CLK);
      for (k = 0; k < 9; k++)
        check(16'(u_far.len[k]), rows[r].div + 16'(rows[r].mod[k % 8]));
      u_far.send(rows[r].rxd);
      for (i = 0; i < 2000 && RX_IRQ !== 1'b1; i++) @(posedge CLK);
      #1 check(RX_IRQ, 1'b1);
      check(TX_IRQ, 1'b0);
      rd(4'h5, v);
      check(v, rows[r].rxd);
      $display("row %0d done", r);
    end
    wr(4'h6, 8'h03);
    settle;
    check(TX_IRQ, 1'b1);
    @(posedge CLK) GLOBAL_IRQ_ENABLE <= 1'b0;
    settle;
    check(TX_IRQ, 1'b0);
    @(posedge CLK) GLOBAL_IRQ_ENABLE <= 1'b1;
    @(posedge CLK) TX_IRQ_ACK <= 1'b1;
    @(posedge CLK) TX_IRQ_ACK <= 1'b0;
    settle;
    check(TX_IRQ, 1'b0);
    wr(4'h4, 8'h55);
    for (i = 0; i < 100 && TX_IRQ !== 1'b1; i++) @(posedge CLK);
    #1 check(TX_IRQ, 1'b1);
    wr(4'h4, 8'haa);
    settle;
    check(TX_IRQ, 1'b0);
    wr(4'h0, 8'h0d);
    settle;
    check(SERIAL_TRANSMIT_PIN, 1'b1);
    check(TX_IRQ, 1'b0);
    rd(4'h7, v);
    check(v, 8'h01);
    rd(4'h6, v);
    check(v, 8'h00);
    $display("interrupt tests done");
    @(posedge CLK) SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK);
    #1 check(SERIAL_TRANSMIT_PIN, 1'b1);
    @(posedge CLK) SYS_RST <= 1'b0;
    rd(4'h7, v);
    check(v, 8'h01);
    rd(4'h6, v);
    check(v, 8'h00);
    rd(4'h9, v);
    check(v, 8'h00);
    $display("reset tests done");
    results;
  end
endmodule // ubt_top_tb
`default_nettype wire
